// >>> hw/sca_consts.vh
`ifndef SCA_CONSTS_VH
`define SCA_CONSTS_VH

// Register byte offsets.
`define SCA_OFF_ADDR_MASK 8'h40
`define SCA_OFF_LEAD_TRAIL 8'h44
`define SCA_OFF_TIMER_CFG 8'h48
`define SCA_OFF_VERSION 8'h4C
`define SCA_OFF_EVT_FLAGS 8'h50
`define SCA_OFF_EVT_MASK 8'h54

// Reset values.
`define SCA_RST_ADDR_MASK 32'h0000_0000
`define SCA_RST_LEAD_TRAIL 32'h0000_0000
`define SCA_RST_TIMER_CFG 32'h0000_0000
`define SCA_RST_EVT_MASK 32'h0707_FD3F

// Event bit positions.
`define SCA_EV_RX_START 0
`define SCA_EV_RX_LEVEL 1
`define SCA_EV_RX_DONE 2
`define SCA_EV_RX_REC_OVF 3
`define SCA_EV_RX_DATA_OVF 4
`define SCA_EV_RX_LOST 5
`define SCA_EV_TIMER 8
`define SCA_EV_RX_DMA_NOTIFY 10
`define SCA_EV_TX_DMA_NOTIFY 11
`define SCA_EV_RX_DMA_DONE 12
`define SCA_EV_TX_DMA_DONE 13
`define SCA_EV_RX_DMA_HALT 14
`define SCA_EV_TX_DMA_HALT 15
`define SCA_EV_TX_LEVEL 16
`define SCA_EV_ALL_SENT 17
`define SCA_EV_TX_UNDERRUN 18
`define SCA_EV_CTS_CHG 24
`define SCA_EV_DSR_CHG 25
`define SCA_EV_CD_CHG 26
`define SCA_EV_VALID 32'h0707_FD3F

// Field positions.
`define SCA_LEAD_CNT_MSB 31
`define SCA_LEAD_CNT_LSB 24
`define SCA_LEAD_PAT_MSB 23
`define SCA_LEAD_PAT_LSB 16
`define SCA_TRAIL_CNT_MSB 15
`define SCA_TRAIL_CNT_LSB 8
`define SCA_TRAIL_PAT_MSB 7
`define SCA_TRAIL_PAT_LSB 0
`define SCA_TMR_SEL_MSB 1
`define SCA_TMR_SEL_LSB 0
`define SCA_TMR_ONESHOT 2
`define SCA_TMR_CNT_MSB 31
`define SCA_TMR_CNT_LSB 3

// Timer clock source codes.
`define SCA_TSEL_OSC 2'h0
`define SCA_TSEL_TXCLK 2'h1
`define SCA_TSEL_RXCLK 2'h2
`define SCA_TSEL_BUS 2'h3

// Receive frame start modes.
`define SCA_FMODE_ADDR 2'h0
`define SCA_FMODE_FLAG 2'h1
`define SCA_FMODE_SYNC 2'h2

// Queue limits.
`define SCA_REC_LIMIT 10'h200
`define SCA_RXFIFO_DEPTH 14'h2000

// AHB transfer codes.
`define SCA_HTRANS_NONSEQ 2'h2
`define SCA_HTRANS_SEQ 2'h3

`endif

// >>> hw/sca_aux_regs.v
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/100ps
`include "sca_consts.vh"

module sca_aux_regs #(
    parameter [7:0] FW_REVISION = 8'h01,
    // Arbitrary neutral identity values.
    parameter [7:0] BUS_REVISION = 8'h01,
    parameter [15:0] BUS_DEVICE_ID = 16'h0001
) (
    input wire clock,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    output reg irq,
    input wire [15:0] rxAddress,
    input wire rxAddrStrobe,
    input wire addr16Mode,
    input wire [15:0] stationCompare,
    input wire [15:0] groupCompare,
    input wire [1:0] frameStartMode,
    input wire rxStartFlag,
    input wire rxFrameSyncInput,
    output reg addrMatch,
    output reg addrMatchValid,
    input wire [13:0] rxLevel,
    input wire [13:0] rxLevelThreshold,
    input wire rxDataPush,
    input wire rxRecordWrite,
    input wire rxStatusAppend,
    input wire [9:0] rxRecordCount,
    input wire rxMessageStore,
    output reg rxFrameLostTag,
    input wire oscTick,
    input wire txClockTick,
    input wire rxClockTick,
    input wire txDescStop,
    input wire rxDescStop,
    input wire txDescFrameEnd,
    input wire rxDescFrameEnd,
    input wire txDescNotify,
    input wire rxDescNotify,
    input wire txResume,
    input wire rxResume,
    output reg txDmaHalted,
    output reg rxDmaHalted,
    input wire [13:0] txLevel,
    input wire [13:0] txLevelThreshold,
    input wire transmitFrameCmd,
    input wire txActive,
    input wire [31:0] txPushedCount,
    input wire [31:0] txFrameLength,
    input wire leadStart,
    input wire trailStart,
    input wire patternTaken,
    output reg [7:0] patternByte,
    output reg patternValid,
    output reg stuffInhibit,
    input wire clearToSend,
    input wire dataSetReady,
    input wire carrierDetect
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LEAD = 3'b010;
    localparam [2:0] ST_TRAIL = 3'b100;

    reg [31:0] addrMask_q;
    reg [31:0] leadTrail_q;
    reg [31:0] timerCfg_q;
    reg [31:0] evtFlags_q;
    reg [31:0] evtMask_q;
    reg [7:0] wrAddr_q;
    reg wrPend_q;
    reg [28:0] timerCnt_q;
    reg timerRun_q;
    reg rxAboveThr_q;
    reg txBelowThr_q;
    reg txActive_q;
    reg cts_q;
    reg dsr_q;
    reg cd_q;
    reg [2:0] seqState_q;
    reg [7:0] seqLeft_q;
    reg [31:0] rdData;
    reg [31:0] evt;
    reg timerTick;

    wire addrPhase = hsel & hready & (htrans == `SCA_HTRANS_NONSEQ || htrans == `SCA_HTRANS_SEQ);
    wire wrHit = wrPend_q;
    wire [31:0] wrVal = hwdata;
    wire [15:0] stationMask = addrMask_q[31:16];
    wire [15:0] groupMask = addrMask_q[15:0];
    wire [15:0] widthMask = addr16Mode ? 16'hFFFF : 16'h00FF;
    wire stationHit = &(~((rxAddress ^ stationCompare) & ~stationMask & widthMask));
    wire groupHit = &(~((rxAddress ^ groupCompare) & ~groupMask & widthMask));
    wire [28:0] timerReload = timerCfg_q[`SCA_TMR_CNT_MSB:`SCA_TMR_CNT_LSB];
    wire timerExpire = timerRun_q & timerTick & (timerCnt_q == 29'h0000_0000);
    wire rxAboveThr = rxLevel > rxLevelThreshold;
    wire txBelowThr = txLevel < txLevelThreshold;
    wire frameStart;

    //////////////////////////////////////////////////////////////////////////////////
    // Frame start select.
    assign frameStart = (frameStartMode == `SCA_FMODE_ADDR) ? (rxAddrStrobe & (stationHit | groupHit)) :
                        (frameStartMode == `SCA_FMODE_FLAG) ? rxStartFlag :
                        (frameStartMode == `SCA_FMODE_SYNC) ? rxFrameSyncInput : 1'b0;

    //////////////////////////////////////////////////////////////////////////////////
    // Read mux, sampled in the address phase.
    always @* begin
        rdData = 32'h0000_0000;
        case (haddr[7:0])
            `SCA_OFF_ADDR_MASK: rdData = addrMask_q;
            `SCA_OFF_LEAD_TRAIL: rdData = leadTrail_q;
            `SCA_OFF_TIMER_CFG: rdData = timerCfg_q;
            `SCA_OFF_VERSION: rdData = {BUS_DEVICE_ID, BUS_REVISION, FW_REVISION};
            `SCA_OFF_EVT_FLAGS: rdData = evtFlags_q;
            `SCA_OFF_EVT_MASK: rdData = evtMask_q;
            default: rdData = 32'h0000_0000;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Timer source select.
    always @* begin
        case (timerCfg_q[`SCA_TMR_SEL_MSB:`SCA_TMR_SEL_LSB])
            `SCA_TSEL_OSC: timerTick = oscTick;
            `SCA_TSEL_TXCLK: timerTick = txClockTick;
            `SCA_TSEL_RXCLK: timerTick = rxClockTick;
            `SCA_TSEL_BUS: timerTick = 1'b1;
            default: timerTick = 1'b0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Raw events, before masking.
    always @* begin
        evt = 32'h0000_0000;
        evt[`SCA_EV_RX_START] = frameStart;
        evt[`SCA_EV_RX_LEVEL] = rxAboveThr & ~rxAboveThr_q;
        evt[`SCA_EV_RX_DONE] = rxRecordWrite | rxStatusAppend;
        evt[`SCA_EV_RX_REC_OVF] = rxRecordWrite & (rxRecordCount >= `SCA_REC_LIMIT);
        evt[`SCA_EV_RX_DATA_OVF] = rxDataPush & (rxLevel >= `SCA_RXFIFO_DEPTH);
        evt[`SCA_EV_RX_LOST] = frameStart & evtFlags_q[`SCA_EV_RX_DATA_OVF];
        evt[`SCA_EV_TIMER] = timerExpire;
        evt[`SCA_EV_RX_DMA_NOTIFY] = rxDescNotify;
        evt[`SCA_EV_TX_DMA_NOTIFY] = txDescNotify;
        evt[`SCA_EV_RX_DMA_DONE] = rxDescFrameEnd;
        evt[`SCA_EV_TX_DMA_DONE] = txDescFrameEnd;
        evt[`SCA_EV_RX_DMA_HALT] = rxDescStop;
        evt[`SCA_EV_TX_DMA_HALT] = txDescStop;
        // Falling below threshold, or send started below it.
        evt[`SCA_EV_TX_LEVEL] = (txBelowThr & ~txBelowThr_q) | (transmitFrameCmd & txBelowThr);
        evt[`SCA_EV_ALL_SENT] = txActive_q & ~txActive;
        evt[`SCA_EV_TX_UNDERRUN] = txActive_q & ~txActive & (txPushedCount < txFrameLength);
        evt[`SCA_EV_CTS_CHG] = clearToSend ^ cts_q;
        evt[`SCA_EV_DSR_CHG] = dataSetReady ^ dsr_q;
        evt[`SCA_EV_CD_CHG] = carrierDetect ^ cd_q;
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Bus slave: no wait states, always OKAY.
    always @(posedge clock) begin
        if (!resetn) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_q <= addrPhase & hwrite;
            if (addrPhase) begin
                wrAddr_q <= haddr[7:0];
            end
            if (addrPhase & ~hwrite) begin
                hrdata <= rdData;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    always @(posedge clock) begin
        if (!resetn) begin
            addrMask_q <= `SCA_RST_ADDR_MASK;
            leadTrail_q <= `SCA_RST_LEAD_TRAIL;
            timerCfg_q <= `SCA_RST_TIMER_CFG;
            evtMask_q <= `SCA_RST_EVT_MASK;
        end else if (wrHit) begin
            if (wrAddr_q == `SCA_OFF_ADDR_MASK) begin
                addrMask_q <= wrVal;
            end
            if (wrAddr_q == `SCA_OFF_LEAD_TRAIL) begin
                leadTrail_q <= wrVal;
            end
            if (wrAddr_q == `SCA_OFF_TIMER_CFG) begin
                timerCfg_q <= wrVal;
            end
            if (wrAddr_q == `SCA_OFF_EVT_MASK) begin
                evtMask_q <= wrVal & `SCA_EV_VALID;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Event flags. A set in the clearing cycle wins, so no event is lost.
    always @(posedge clock) begin
        if (!resetn) begin
            evtFlags_q <= 32'h0000_0000;
            irq <= 1'b0;
        end else begin
            // Write one to clear; set wins.
            evtFlags_q <= (evtFlags_q & ~((wrHit && wrAddr_q == `SCA_OFF_EVT_FLAGS) ? wrVal : 32'h0000_0000))
                          | (evt & ~evtMask_q & `SCA_EV_VALID);
            irq <= |(evtFlags_q & ~evtMask_q);
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Timer. A write to its register restarts it from the new count.
    always @(posedge clock) begin
        if (!resetn) begin
            timerCnt_q <= 29'h0000_0000;
            timerRun_q <= 1'b0;
        end else if (wrHit && wrAddr_q == `SCA_OFF_TIMER_CFG) begin
            timerCnt_q <= wrVal[`SCA_TMR_CNT_MSB:`SCA_TMR_CNT_LSB];
            timerRun_q <= 1'b1;
        end else if (timerExpire) begin
            // Count plus one ticks per period.
            timerCnt_q <= timerReload;
            timerRun_q <= ~timerCfg_q[`SCA_TMR_ONESHOT];
        end else if (timerRun_q & timerTick) begin
            timerCnt_q <= timerCnt_q - 29'h0000_0001;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Receive side state, DMA halt and edge history.
    always @(posedge clock) begin
        if (!resetn) begin
            addrMatch <= 1'b0;
            addrMatchValid <= 1'b0;
            rxFrameLostTag <= 1'b0;
            txDmaHalted <= 1'b0;
            rxDmaHalted <= 1'b0;
            rxAboveThr_q <= 1'b0;
            txBelowThr_q <= 1'b0;
            txActive_q <= 1'b0;
            cts_q <= 1'b0;
            dsr_q <= 1'b0;
            cd_q <= 1'b0;
        end else begin
            addrMatchValid <= rxAddrStrobe;
            if (rxAddrStrobe) begin
                addrMatch <= stationHit | groupHit;
            end
            if (frameStart & evtFlags_q[`SCA_EV_RX_DATA_OVF]) begin
                rxFrameLostTag <= 1'b1;
            end else if (rxMessageStore) begin
                rxFrameLostTag <= 1'b0;
            end
            // Halt until resume; a stop beats a resume.
            if (txDescStop) begin
                txDmaHalted <= 1'b1;
            end else if (txResume) begin
                txDmaHalted <= 1'b0;
            end
            if (rxDescStop) begin
                rxDmaHalted <= 1'b1;
            end else if (rxResume) begin
                rxDmaHalted <= 1'b0;
            end
            rxAboveThr_q <= rxAboveThr;
            txBelowThr_q <= txBelowThr;
            txActive_q <= txActive;
            cts_q <= clearToSend;
            dsr_q <= dataSetReady;
            cd_q <= carrierDetect;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////
    // Lead and trailer sequencer; one byte per patternTaken.
    always @(posedge clock) begin
        if (!resetn) begin
            seqState_q <= ST_IDLE;
            seqLeft_q <= 8'h00;
            patternByte <= 8'h00;
            patternValid <= 1'b0;
            stuffInhibit <= 1'b0;
        end else begin
            case (seqState_q)
                ST_IDLE: begin
                    if (leadStart && leadTrail_q[`SCA_LEAD_CNT_MSB:`SCA_LEAD_CNT_LSB] != 8'h00) begin
                        seqState_q <= ST_LEAD;
                        seqLeft_q <= leadTrail_q[`SCA_LEAD_CNT_MSB:`SCA_LEAD_CNT_LSB];
                        patternByte <= leadTrail_q[`SCA_LEAD_PAT_MSB:`SCA_LEAD_PAT_LSB];
                        patternValid <= 1'b1;
                    end else if (trailStart && leadTrail_q[`SCA_TRAIL_CNT_MSB:`SCA_TRAIL_CNT_LSB] != 8'h00) begin
                        seqState_q <= ST_TRAIL;
                        seqLeft_q <= leadTrail_q[`SCA_TRAIL_CNT_MSB:`SCA_TRAIL_CNT_LSB];
                        patternByte <= leadTrail_q[`SCA_TRAIL_PAT_MSB:`SCA_TRAIL_PAT_LSB];
                        patternValid <= 1'b1;
                        stuffInhibit <= 1'b1;
                    end
                end
                ST_LEAD, ST_TRAIL: begin
                    if (patternTaken) begin
                        seqLeft_q <= seqLeft_q - 8'h01;
                        if (seqLeft_q == 8'h01) begin
                            seqState_q <= ST_IDLE;
                            patternValid <= 1'b0;
                            stuffInhibit <= 1'b0;
                        end
                    end
                end
                default: begin
                    seqState_q <= ST_IDLE;
                    patternValid <= 1'b0;
                    stuffInhibit <= 1'b0;
                end
            endcase
        end
    end

endmodule // sca_aux_regs

// >>> bench/sca_aux_regs_sva.sv
`timescale 1ns/100ps
`include "sca_consts.vh"
module sca_aux_regs_sva #(
    parameter [7:0] FW_REVISION = 8'h01,
    parameter [7:0] BUS_REVISION = 8'h01,
    parameter [15:0] BUS_DEVICE_ID = 16'h0001
) (
    input wire clock,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    input wire rxAddrStrobe,
    input wire addrMatchValid,
    input wire txDescStop,
    input wire rxDescStop,
    input wire txResume,
    input wire txDmaHalted,
    input wire rxDmaHalted,
    input wire leadStart,
    input wire trailStart,
    input wire patternValid,
    input wire stuffInhibit
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    sequence verRead;
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == `SCA_OFF_VERSION;
    endsequence
    version_read_a: assert property (verRead |=> hrdata == {BUS_DEVICE_ID, BUS_REVISION, FW_REVISION})
        else $error("version read");
    okay_resp_a: assert property (!hresp)
        else $error("response");
    ready_up_a: assert property ($past(resetn) |-> hreadyout)
        else $error("ready");
    tx_halt_set_a: assert property (txDescStop |=> txDmaHalted)
        else $error("tx halt");
    rx_halt_set_a: assert property (rxDescStop |=> rxDmaHalted)
        else $error("rx halt");
    halt_hold_a: assert property (txDmaHalted && !txResume |=> txDmaHalted)
        else $error("halt hold");
    match_pulse_a: assert property (addrMatchValid == $past(rxAddrStrobe))
        else $error("match valid");
    pattern_cause_a: assert property ($rose(patternValid) |-> $past(leadStart || trailStart))
        else $error("pattern cause");
    trail_inhibit_a: assert property ($rose(stuffInhibit) |-> $past(trailStart) && patternValid)
        else $error("inhibit");
endmodule // sca_aux_regs_sva

bind sca_aux_regs sca_aux_regs_sva #(.FW_REVISION(FW_REVISION), .BUS_REVISION(BUS_REVISION),
    .BUS_DEVICE_ID(BUS_DEVICE_ID)) u_sca_aux_regs_sva (.*);

// >>> bench/sca_remote_station.sv
`timescale 1ns/100ps
module sca_remote_station (
    input wire clock,
    input wire resetn,
    input wire patternValid,
    input wire [7:0] patternByte,
    input wire stuffInhibit,
    input wire [2:0] modemReq,
    input wire [1:0] gap,
    output reg patternTaken,
    output reg clearToSend,
    output reg dataSetReady,
    output reg carrierDetect,
    output reg [7:0] takenCount,
    output reg [7:0] lastByte,
    output reg lastInhibit
);
    reg [1:0] wait_q;
    always @(posedge clock) begin
        if (!resetn) begin
            {carrierDetect, dataSetReady, clearToSend} <= 3'h0;
            patternTaken <= 1'b0;
            takenCount <= 8'h00;
            lastByte <= 8'h00;
            lastInhibit <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            {carrierDetect, dataSetReady, clearToSend} <= modemReq;
            patternTaken <= 1'b0;
            if (patternValid && !patternTaken) begin
                if (wait_q >= gap) begin
                    patternTaken <= 1'b1;
                    takenCount <= takenCount + 8'h01;
                    lastByte <= patternByte;
                    lastInhibit <= stuffInhibit;
                    wait_q <= 2'h0;
                end else begin
                    wait_q <= wait_q + 2'h1;
                end
            end
        end
    end
endmodule // sca_remote_station

// >>> bench/testbench.sv
`timescale 1ns/100ps
`include "sca_consts.vh"
module testbench;
    reg clock = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, addr16Mode = 1'b1;
    reg txActive = 1'b0;
    reg [1:0] htrans = 2'h0, fsMode = 2'h1;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, txPushed = 32'h0, txLen = 32'h5, rd, base;
    reg [17:0] pls = 18'h0;
    reg [2:0] tick = 3'h0, modemReq = 3'h0;
    reg [15:0] rxAddress = 16'h0, grpCmp = 16'h5678, stnCmp = 16'h1234;
    reg [13:0] rxLevel = 14'h0, txLevel = 14'h0, thr = 14'h5;
    reg [9:0] recCount = 10'h200;
    wire hreadyout, hresp, irq, addrMatch, amValid, lostTag, txHalt, rxHalt;
    wire patternValid, stuffInhibit, patternTaken, cts, dsr, cd, lastInhibit;
    wire [7:0] patternByte, takenCount, lastByte;
    wire [31:0] hrdata;
    integer num_errors = 0, checks_done = 0, i;
    reg [95:0] regRows [0:7] = '{{32'h40, 32'hFFFFFFFF, 32'hFFFFFFFF},
        {32'h44, 32'hA5A55A5A, 32'hA5A55A5A}, {32'h48, 32'h14, 32'h14},
        {32'h4C, 32'hFFFFFFFF, 32'h12343C5A}, {32'h5C, 32'hFFFFFFFF, 32'h0},
        {32'h54, 32'hFFFFFFFF, 32'h0707FD3F}, {32'h54, 32'h0, 32'h0}, {32'h40, 32'h0, 32'h0}};
    reg [63:0] evRows [0:10] = '{{32'h1, 32'h1}, {32'h2, 32'h0}, {32'h4, 32'hC},
        {32'h8, 32'h4}, {32'h10, 32'h0}, {32'h40, 32'h8000}, {32'h80, 32'h4000},
        {32'h100, 32'h2000}, {32'h200, 32'h1000}, {32'h400, 32'h800}, {32'h800, 32'h400}};
    sca_aux_regs #(.FW_REVISION(8'h5A), .BUS_REVISION(8'h3C), .BUS_DEVICE_ID(16'h1234))
    u_sca_aux_regs (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .rxAddress,
        .rxAddrStrobe(pls[16]), .addr16Mode, .stationCompare(stnCmp), .groupCompare(grpCmp),
        .frameStartMode(fsMode), .rxStartFlag(pls[0]), .rxFrameSyncInput(pls[1]), .addrMatch,
        .addrMatchValid(amValid), .rxLevel, .rxLevelThreshold(thr), .rxDataPush(pls[4]),
        .rxRecordWrite(pls[2]), .rxStatusAppend(pls[3]), .rxRecordCount(recCount),
        .rxMessageStore(pls[5]), .rxFrameLostTag(lostTag), .oscTick(tick[0]),
        .txClockTick(tick[1]), .rxClockTick(tick[2]), .txDescStop(pls[6]), .rxDescStop(pls[7]),
        .txDescFrameEnd(pls[8]), .rxDescFrameEnd(pls[9]), .txDescNotify(pls[10]),
        .rxDescNotify(pls[11]), .txResume(pls[12]), .rxResume(pls[13]), .txDmaHalted(txHalt),
        .rxDmaHalted(rxHalt), .txLevel, .txLevelThreshold(thr), .transmitFrameCmd(pls[17]),
        .txActive, .txPushedCount(txPushed), .txFrameLength(txLen), .leadStart(pls[14]),
        .trailStart(pls[15]), .patternTaken, .patternByte, .patternValid, .stuffInhibit,
        .clearToSend(cts), .dataSetReady(dsr), .carrierDetect(cd));
    sca_remote_station u_sca_remote_station (.clock, .resetn, .patternValid, .patternByte,
        .stuffInhibit, .modemReq, .gap(2'h1), .patternTaken, .clearToSend(cts),
        .dataSetReady(dsr), .carrierDetect(cd), .takenCount, .lastByte, .lastInhibit);
    always #20 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        begin
            $display("checks %0d errors %0d", checks_done, num_errors);
            if (num_errors == 0 && checks_done > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task check(input string nm, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("[FAIL] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge clock);
    endtask
    task waitRdy;
        integer n;
        begin
            n = 0;
            @(posedge clock);
            while (hreadyout !== 1'b1) begin
                n = n + 1;
                if (n > 50) begin
                    num_errors = num_errors + 1;
                    end_sim;
                end
                @(posedge clock);
            end
        end
    endtask
    task xfer(input wr, input [7:0] a, input [31:0] d);
        begin
            hsel <= 1'b1;
            htrans <= `SCA_HTRANS_NONSEQ;
            hwrite <= wr;
            haddr <= {24'h0, a};
            waitRdy;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            waitRdy;
            rd = hrdata;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task rdchk(input string nm, input [7:0] a, input [31:0] e);
        begin
            xfer(1'b0, a, 32'h0);
            check(nm, e, rd);
        end
    endtask
    task clr;
        wr(`SCA_OFF_EVT_FLAGS, 32'hFFFFFFFF);
    endtask
    task pulse(input [17:0] p);
        begin
            pls <= p;
            @(posedge clock);
            pls <= 18'h0;
        end
    endtask
    task tk(input [2:0] t, input integer n);
        repeat (n) begin
            tick <= t;
            cyc(1);
            tick <= 3'h0;
            cyc(1);
        end
    endtask
    task fs(input [1:0] m, input [17:0] p, input [31:0] e);
        begin
            fsMode <= m;
            pulse(p);
            rdchk("frameStart", `SCA_OFF_EVT_FLAGS, e);
            clr;
        end
    endtask
    task am(input [31:0] m, input [15:0] a, input e);
        begin
            wr(`SCA_OFF_ADDR_MASK, m);
            rxAddress <= a;
            pulse(18'h10000);
            cyc(1);
            check("addrMatch", {31'h0, e}, {31'h0, addrMatch});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(3);
        resetn <= 1'b1;
        cyc(1);
        pulse(18'h40);
        rdchk("maskedFlags", `SCA_OFF_EVT_FLAGS, 32'h0);
        check("maskedIrq", 32'h0, {31'h0, irq});
        pulse(18'h3000);
        for (i = 0; i < 8; i = i + 1) begin
            rdchk("resetVal", regRows[i][71:64], (i < 3) ? 32'h0 : (i > 5) ?
                regRows[(i == 6) ? 5 : 0][31:0] : regRows[i][31:0]);
            wr(regRows[i][71:64], regRows[i][63:32]);
            rdchk("readBack", regRows[i][71:64], regRows[i][31:0]);
        end
        for (i = 0; i < 11; i = i + 1) begin
            pulse(evRows[i][49:32]);
            rdchk("flags", `SCA_OFF_EVT_FLAGS, evRows[i][31:0]);
            check("irq", {31'h0, evRows[i][31:0] != 0}, {31'h0, irq});
            clr;
        end
        pulse(18'h3FC0);
        cyc(1);
        check("stopWins", 32'h3, {30'h0, rxHalt, txHalt});
        pulse(18'h3000);
        cyc(1);
        check("resumed", 32'h0, {30'h0, rxHalt, txHalt});
        clr;
        recCount <= 10'h1FF;
        pulse(18'h4);
        rdchk("recLimit", `SCA_OFF_EVT_FLAGS, 32'h4);
        clr;
        for (i = 0; i < 3; i = i + 1) begin
            modemReq <= modemReq | (3'h1 << i);
            cyc(2);
            rdchk("modem", `SCA_OFF_EVT_FLAGS, 32'h1 << (24 + i));
            clr;
        end
        modemReq <= 3'h0;
        cyc(2);
        rdchk("modemAll", `SCA_OFF_EVT_FLAGS, 32'h07000000);
        clr;
        rxAddress <= 16'h1234;
        fs(2'h2, 18'h2, 32'h1);
        fs(2'h3, 18'h1, 32'h0);
        fs(2'h0, 18'h10000, 32'h1);
        am(32'h0, 16'h1235, 1'b0);
        am(32'h10000, 16'h1235, 1'b1);
        am(32'h0, 16'h5679, 1'b0);
        am(32'h1, 16'h5679, 1'b1);
        am(32'h10000, 16'h5679, 1'b0);
        addr16Mode <= 1'b0;
        am(32'h0, 16'h9934, 1'b1);
        addr16Mode <= 1'b1;
        wr(`SCA_OFF_ADDR_MASK, 32'h0);
        clr;
        fsMode <= 2'h1;
        rxLevel <= 14'h1FFF;
        cyc(2);
        rdchk("rxLevel", `SCA_OFF_EVT_FLAGS, 32'h2);
        clr;
        pulse(18'h10);
        rdchk("fifoFull", `SCA_OFF_EVT_FLAGS, 32'h0);
        rxLevel <= 14'h2000;
        pulse(18'h10);
        pulse(18'h1);
        rdchk("overflow", `SCA_OFF_EVT_FLAGS, 32'h31);
        check("lostTag", 32'h1, {31'h0, lostTag});
        pulse(18'h20);
        cyc(1);
        check("lostTagClr", 32'h0, {31'h0, lostTag});
        txLevel <= 14'hA;
        cyc(2);
        clr;
        txLevel <= 14'h2;
        cyc(2);
        rdchk("txLevel", `SCA_OFF_EVT_FLAGS, 32'h10000);
        clr;
        pulse(18'h20000);
        rdchk("txCmd", `SCA_OFF_EVT_FLAGS, 32'h10000);
        txPushed <= 32'h3;
        txActive <= 1'b1;
        cyc(2);
        clr;
        txActive <= 1'b0;
        cyc(2);
        rdchk("underrun", `SCA_OFF_EVT_FLAGS, 32'h60000);
        clr;
        txPushed <= 32'h5;
        txActive <= 1'b1;
        cyc(2);
        txActive <= 1'b0;
        cyc(2);
        rdchk("allSent", `SCA_OFF_EVT_FLAGS, 32'h20000);
        wr(`SCA_OFF_LEAD_TRAIL, 32'h03A5023C);
        base = takenCount;
        pulse(18'h4000);
        cyc(14);
        check("leadSent", base + 3, lastInhibit ? 32'h0 : takenCount);
        check("leadByte", 32'hA5, lastByte);
        pulse(18'h8000);
        cyc(14);
        check("trailSent", base + 5, takenCount);
        check("trailInhibit", 32'h13C, {lastInhibit, lastByte});
        wr(`SCA_OFF_LEAD_TRAIL, 32'h00A5003C);
        pulse(18'hC000);
        cyc(8);
        check("countZero", base + 5, takenCount);
        for (i = 0; i < 3; i = i + 1) begin
            wr(`SCA_OFF_TIMER_CFG, {29'h1, 1'b0, i[1:0]});
            clr;
            tk(~(3'h1 << i), 2);
            tk(3'h1 << i, 1);
            rdchk("timerEarly", `SCA_OFF_EVT_FLAGS, 32'h0);
            tk(3'h1 << i, 1);
            rdchk("timerFire", `SCA_OFF_EVT_FLAGS, 32'h100);
            clr;
            tk(3'h1 << i, 2);
            rdchk("timerReload", `SCA_OFF_EVT_FLAGS, 32'h100);
        end
        wr(`SCA_OFF_TIMER_CFG, {29'h3, 1'b1, 2'h3});
        clr;
        cyc(10);
        rdchk("oneShot", `SCA_OFF_EVT_FLAGS, 32'h100);
        clr;
        cyc(10);
        rdchk("oneShotOnce", `SCA_OFF_EVT_FLAGS, 32'h0);
        pulse(18'h40);
        resetn <= 1'b0;
        cyc(3);
        resetn <= 1'b1;
        cyc(1);
        check("haltReset", 32'h0, {31'h0, txHalt});
        rdchk("leadReset", `SCA_OFF_LEAD_TRAIL, 32'h0);
        rdchk("maskReset", `SCA_OFF_ADDR_MASK, 32'h0);
        rdchk("flagReset", `SCA_OFF_EVT_FLAGS, 32'h0);
        end_sim;
    end
endmodule // testbench
